/* File: hw/fcs_defs.vh */
// Constants for the flash command sequencer
`ifndef FCS_DEFS_VH
`define FCS_DEFS_VH
`define FCS_CLK_HZ 20000000
`define FCS_D_UNLOCK1 32'h0000_00AA
`define FCS_D_UNLOCK2 32'h0000_0055
`define FCS_D_PROGRAM 32'h0000_00A0
`define FCS_D_ERASE 32'h0000_0080
`define FCS_D_CHIP_ERASE 32'h0000_0010
`define FCS_D_BLOCK_ERASE 32'h0000_0030
`define FCS_D_RESET 32'h0000_00F0
`define FCS_CHIP_HI 20
`define FCS_CHIP_LO 19
`define FCS_VA_HI 31
`define FCS_VA_LO 21
`define FCS_RST_SEL 20
`define FCS_PAGE_HI 31
`define FCS_PAGE_LO 9
`define FCS_PAGE_WORDS 8'h80
`define FCS_WORD_STEP 32'h0000_0004
`define FCS_OP_PROGRAM 2'h0
`define FCS_OP_CHIP_ERASE 2'h1
`define FCS_OP_BLOCK_ERASE 2'h2
`define FCS_CYC_PROG_START 3'h3
`define FCS_CYC_ERASE_LAST 3'h5
`define FCS_CYC_STEP 3'h1
`define FCS_CYC_UNLOCK2 3'h1
`define FCS_CYC_CMD 3'h2
`define FCS_CYC_ERASE_AA 3'h3
`define FCS_CYC_ERASE_55 3'h4
`define FCS_AREAS 4
`define FCS_PAGE_TOP_OFS 9'h000
`define FCS_WORD_ONE 8'h01
`endif

/* File: hw/fcs_sequencer.v */
// Flash command sequencer: read mode, command decode and automatic operation control
//
// Overview of operation
// - Automatic mode only from valid sequence in read
// - No read data or fetch while automatic
// - Only hardware reset, ARR_DONE or ARR_FAIL leaves automatic operation
// - Read mode after reset and normal completion
// - Abnormal end locks out read, flag zero
// - Data F0 writes return array to read, except as page data or while busy
// - Read/reset sequence ends after third write, or after second in the two-address form
// - Read/reset cancels partial or wrong sequences
// - Address bits 20:19 equal, select chip
// - Any deviating write abandons the command
// - Pin or watchdog reset aborts to read
// - Programming clears bits; erase sets them
// - Page is 128 words, same bits 31:9
// - Chip erase 1 MB, block erase 128 kB
// - Each 512 kB area separately protectable against program and block erase
// - All four protected blocks writer-mode reads
// - Programming starts at fourth write, words follow
// - Normal program end sets flag, returns read
`timescale 1ns/1ps
`include "fcs_defs.vh"

module fcs_sequencer (
    input wire CLK,
    input wire RST,
    input wire WR_STB,
    input wire [31:0] WR_ADDR,
    input wire [31:0] WR_DATA,
    input wire [3:0] PROTECT,
    input wire WRITER_MODE,
    input wire ARR_DONE,
    input wire ARR_FAIL,
    output wire READY_BUSY_FLAG,
    output wire READ_EN,
    output wire FETCH_EN,
    output wire SECURITY_ON,
    output reg ARR_START,
    output reg [1:0] ARR_OP,
    output reg ARR_CHIP,
    output reg [31:0] ARR_ADDR,
    output reg ARR_WSTB,
    output reg [31:0] ARR_WDATA
);
    localparam [4:0] S_READ = 5'b00001;
    localparam [4:0] S_CMD = 5'b00010;
    localparam [4:0] S_PDATA = 5'b00100;
    localparam [4:0] S_BUSY = 5'b01000;
    localparam [4:0] S_LOCK = 5'b10000;

    reg [4:0] state_q, state_d;
    reg [2:0] cyc_q, cyc_d;
    reg erase_q, erase_d;
    reg [10:0] va_q, va_d;
    reg [7:0] words_q, words_d;
    reg [31:0] addr_d;
    reg [1:0] op_d;
    reg chip_d, start_d, wstb_d;
    reg [31:0] wdata_d;

    wire chip_ok = WR_ADDR[`FCS_CHIP_HI] == WR_ADDR[`FCS_CHIP_LO];
    wire [1:0] area = WR_ADDR[`FCS_CHIP_HI:`FCS_CHIP_LO];
    wire [3:0] area_sel = 4'h1 << area;
    wire [3:0] area_hit;
    wire area_prot = |area_hit;
    wire all_prot = &PROTECT;
    wire is_reset = WR_DATA == `FCS_D_RESET;
    wire first_ok = (state_q == S_CMD) ? (WR_ADDR[`FCS_VA_HI:`FCS_VA_LO] == va_q) : 1'b1;
    wire addr_ok = chip_ok && first_ok;

    // One protection compare per 512 kB area
    genvar g;
    generate
        for (g = 0; g < `FCS_AREAS; g = g + 1) begin : g_area
            assign area_hit[g] = PROTECT[g] & area_sel[g];
        end
    endgenerate

    // Flag low while accepted operation runs or after a failure
    assign READY_BUSY_FLAG = ~(state_q[2] | state_q[3] | state_q[4]);
    assign SECURITY_ON = all_prot;
    assign READ_EN = (state_q == S_READ || state_q == S_CMD) &&
        !(all_prot && WRITER_MODE);
    assign FETCH_EN = state_q == S_READ || state_q == S_CMD;

    always @* begin
        state_d = state_q;
        cyc_d = cyc_q;
        erase_d = erase_q;
        va_d = va_q;
        words_d = words_q;
        addr_d = ARR_ADDR;
        op_d = ARR_OP;
        chip_d = ARR_CHIP;
        wdata_d = ARR_WDATA;
        start_d = 1'b0;
        wstb_d = 1'b0;
        case (state_q)
            S_READ: begin
                if (WR_STB) begin
                    if (WR_DATA == `FCS_D_UNLOCK1 && chip_ok) begin
                        state_d = S_CMD;
                        cyc_d = `FCS_CYC_UNLOCK2;
                        erase_d = 1'b0;
                        va_d = WR_ADDR[`FCS_VA_HI:`FCS_VA_LO];
                    end else if (is_reset && WR_ADDR[`FCS_RST_SEL]) begin
                        // First half of the two-address read/reset form
                        state_d = S_CMD;
                        cyc_d = `FCS_CYC_UNLOCK2;
                        erase_d = 1'b0;
                        va_d = WR_ADDR[`FCS_VA_HI:`FCS_VA_LO];
                    end
                end
            end
            S_CMD: begin
                if (WR_STB) begin
                    cyc_d = cyc_q + `FCS_CYC_STEP;
                    state_d = S_READ;
                    if (is_reset) begin
                        state_d = S_READ;
                    end else if (!addr_ok) begin
                        state_d = S_READ;
                    end else if (cyc_q == `FCS_CYC_UNLOCK2 && WR_DATA == `FCS_D_UNLOCK2) begin
                        state_d = S_CMD;
                    end else if (cyc_q == `FCS_CYC_ERASE_55 && WR_DATA == `FCS_D_UNLOCK2 &&
                        erase_q) begin
                        state_d = S_CMD;
                    end else if (cyc_q == `FCS_CYC_CMD && WR_DATA == `FCS_D_PROGRAM) begin
                        state_d = S_CMD;
                    end else if (cyc_q == `FCS_CYC_CMD && WR_DATA == `FCS_D_ERASE) begin
                        state_d = S_CMD;
                        erase_d = 1'b1;
                    end else if (cyc_q == `FCS_CYC_ERASE_AA && erase_q &&
                        WR_DATA == `FCS_D_UNLOCK1) begin
                        state_d = S_CMD;
                    end else if (cyc_q == `FCS_CYC_PROG_START && !erase_q) begin
                        // Fourth write: page top address plus first data word
                        if (!area_prot) begin
                            state_d = S_PDATA;
                            op_d = `FCS_OP_PROGRAM;
                            addr_d = {WR_ADDR[`FCS_PAGE_HI:`FCS_PAGE_LO], `FCS_PAGE_TOP_OFS};
                            chip_d = WR_ADDR[`FCS_CHIP_HI];
                            wdata_d = WR_DATA;
                            start_d = 1'b1;
                            wstb_d = 1'b1;
                            words_d = `FCS_PAGE_WORDS - `FCS_WORD_ONE;
                        end
                    end else if (cyc_q == `FCS_CYC_ERASE_LAST && erase_q) begin
                        chip_d = WR_ADDR[`FCS_CHIP_HI];
                        addr_d = WR_ADDR;
                        if (WR_DATA == `FCS_D_CHIP_ERASE && !all_prot) begin
                            state_d = S_BUSY;
                            op_d = `FCS_OP_CHIP_ERASE;
                            start_d = 1'b1;
                        end else if (WR_DATA == `FCS_D_BLOCK_ERASE && !area_prot) begin
                            state_d = S_BUSY;
                            op_d = `FCS_OP_BLOCK_ERASE;
                            start_d = 1'b1;
                        end
                    end
                end
            end
            S_PDATA: begin
                // Reset data is plain page data here; only hardware reset or ARR_FAIL aborts
                if (ARR_FAIL) begin
                    state_d = S_LOCK;
                end else if (WR_STB) begin
                    addr_d = ARR_ADDR + `FCS_WORD_STEP;
                    wdata_d = WR_DATA;
                    wstb_d = 1'b1;
                    words_d = words_q - `FCS_WORD_ONE;
                    if (words_q == `FCS_WORD_ONE) begin
                        state_d = S_BUSY;
                    end
                end
            end
            S_BUSY: begin
                // Writes ignored; only reset, ARR_DONE or ARR_FAIL leaves this state
                if (ARR_FAIL) begin
                    state_d = S_LOCK;
                end else if (ARR_DONE) begin
                    state_d = S_READ;
                end
            end
            S_LOCK: begin
                if (WR_STB && is_reset) begin
                    state_d = S_READ;
                end
            end
            default: begin
                state_d = S_READ;
            end
        endcase
    end

    always @(posedge CLK) begin
        if (RST) begin
            state_q <= S_READ;
            cyc_q <= 3'h0;
            erase_q <= 1'b0;
            va_q <= 11'h000;
            words_q <= 8'h00;
            ARR_START <= 1'b0;
            ARR_OP <= 2'h0;
            ARR_CHIP <= 1'b0;
            ARR_ADDR <= 32'h0000_0000;
            ARR_WSTB <= 1'b0;
            ARR_WDATA <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            cyc_q <= cyc_d;
            erase_q <= erase_d;
            va_q <= va_d;
            words_q <= words_d;
            ARR_START <= start_d;
            ARR_OP <= op_d;
            ARR_CHIP <= chip_d;
            ARR_ADDR <= addr_d;
            ARR_WSTB <= wstb_d;
            ARR_WDATA <= wdata_d;
        end
    end
endmodule // fcs_sequencer

/* File: tb/fcs_host_model.sv */
// Host model issuing word stores to the sequencer
`timescale 1ns/1ps
module fcs_host_model (
    input wire clk,
    output logic stb,
    output logic [31:0] addr,
    output logic [31:0] data
);
    initial begin
        stb = 1'b0;
        addr = 32'h0000_0000;
        data = 32'h0000_0000;
    end
    // One word store, then bus released and idle gap
    task automatic store(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        stb <= 1'b1;
        addr <= a;
        data <= d;
        @(posedge clk);
        stb <= 1'b0;
        addr <= ~a;
        data <= ~d;
        repeat (15) @(posedge clk);
    endtask
endmodule // fcs_host_model

/* File: tb/fcs_properties.sv */
// Port assertions for the flash command sequencer
`timescale 1ns/1ps
module fcs_properties (
    input wire CLK,
    input wire RST,
    input wire WR_STB,
    input wire [3:0] PROTECT,
    input wire WRITER_MODE,
    input wire READY_BUSY_FLAG,
    input wire READ_EN,
    input wire FETCH_EN,
    input wire SECURITY_ON,
    input wire ARR_START,
    input wire [1:0] ARR_OP,
    input wire ARR_WSTB
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    busy_no_read_a: assert property (!READY_BUSY_FLAG |-> !READ_EN && !FETCH_EN)
        else $error("array readable while not ready");
    secure_flag_a: assert property (SECURITY_ON == &PROTECT)
        else $error("security does not follow protection");
    secure_read_a: assert property (SECURITY_ON && WRITER_MODE |-> !READ_EN)
        else $error("secured array readable in writer mode");
    start_busy_a: assert property (ARR_START |-> !READY_BUSY_FLAG ##1 !READY_BUSY_FLAG)
        else $error("flag ready after start");
    reset_ready_a: assert property ($fell(RST) |-> READY_BUSY_FLAG && !ARR_START)
        else $error("not ready after reset");
    start_cause_a: assert property (ARR_START |-> $past(WR_STB))
        else $error("start without a store");
    prog_word_a: assert property (ARR_START && ARR_OP == 2'h0 |-> ARR_WSTB)
        else $error("program start without first word");
    wstb_cause_a: assert property (ARR_WSTB |-> $past(WR_STB))
        else $error("page word without a store");
endmodule // fcs_properties

/* File: tb/testbench.sv */
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst, writer_mode, arr_done, arr_fail, stb, flag, read_en, fetch_en, sec_on;
    logic arr_start, arr_chip, arr_wstb;
    logic [3:0] protect;
    logic [1:0] arr_op;
    logic [31:0] addr, data, arr_addr, arr_wdata;
    int n_errors = 0;
    int n_tests = 0;
    int n_start = 0;
    int n_wstb = 0;
    int cycles = 0;
    always #25 clk = ~clk;
    fcs_host_model h (.clk(clk), .stb(stb), .addr(addr), .data(data));
    fcs_sequencer dut (.CLK(clk), .RST(rst), .WR_STB(stb), .WR_ADDR(addr), .WR_DATA(data),
        .PROTECT(protect), .WRITER_MODE(writer_mode), .ARR_DONE(arr_done), .ARR_FAIL(arr_fail),
        .READY_BUSY_FLAG(flag), .READ_EN(read_en), .FETCH_EN(fetch_en), .SECURITY_ON(sec_on),
        .ARR_START(arr_start), .ARR_OP(arr_op), .ARR_CHIP(arr_chip), .ARR_ADDR(arr_addr),
        .ARR_WSTB(arr_wstb), .ARR_WDATA(arr_wdata));
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (arr_start) n_start <= n_start + 1;
        if (arr_wstb) n_wstb <= n_wstb + 1;
        if (cycles == 10000) begin
            n_errors++;
            end_of_test;
        end
    end
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic unlock(input logic [31:0] a);
        @(negedge clk);
        check(flag, 1);
        h.store(a, 32'h0000_00AA);
        h.store(a, 32'h0000_0055);
    endtask
    task automatic pulse_end(input logic fail);
        @(posedge clk);
        arr_done <= !fail;
        arr_fail <= fail;
        @(posedge clk);
        arr_done <= 1'b0;
        arr_fail <= 1'b0;
        @(negedge clk);
    endtask
    task automatic t_program;
        unlock(32'h0000_0000);
        h.store(32'h0000_0000, 32'h0000_00A0);
        for (int i = 0; i < 128; i++) begin
            h.store(32'h0000_0200 + 4 * i, i);
            @(negedge clk);
            if (i == 0) begin
                check(n_start, 1);
                check(arr_op, 0);
                check({flag, read_en, fetch_en}, 0);
            end
        end
        check(n_wstb, 128);
        check(arr_addr, 32'h0000_03FC);
        check(arr_wdata, 32'h0000_007F);
        h.store(32'h0000_0000, 32'h0000_00AA);
        check(n_start, 1);
        h.store(32'h0000_0000, 32'h0000_00F0);
        check(flag, 0);
        pulse_end(1'b0);
        check({flag, read_en}, 3);
        $display("program test done");
    endtask
    task automatic t_erase(input logic [31:0] a, input logic [31:0] code, input logic fail);
        unlock(a);
        h.store(a, 32'h0000_0080);
        unlock(a);
        h.store(a, code);
        @(negedge clk);
        check(arr_op, code == 32'h0000_0010 ? 1 : 2);
        check(arr_chip, a[20]);
        check(flag, 0);
        if (fail) begin
            pulse_end(1'b1);
            check({flag, read_en}, 0);
            h.store(a, 32'h0000_00F0);
            check(flag, 1);
        end else begin
            @(posedge clk);
            rst <= 1'b1;
            @(posedge clk);
            rst <= 1'b0;
            @(negedge clk);
            check({flag, read_en}, 3);
        end
        $display("erase test done");
    endtask
    task automatic t_bad;
        h.store(32'h0000_0000, 32'h0000_00AA);
        h.store(32'h0000_0000, 32'h0000_0056);
        h.store(32'h0000_0000, 32'h0000_00A0);
        h.store(32'h0000_0200, 32'h0000_0000);
        check(n_start, 3);
        unlock(32'h0000_0000);
        h.store(32'h0000_0000, 32'h0000_00F0);
        h.store(32'h0000_0000, 32'h0000_00A0);
        h.store(32'h0000_0200, 32'h0000_0000);
        check(n_start, 3);
        h.store(32'h0010_0000, 32'h0000_00F0);
        h.store(32'h0000_0000, 32'h0000_00F0);
        check({flag, read_en}, 3);
        @(posedge clk);
        protect <= 4'h8;
        unlock(32'h0018_0000);
        h.store(32'h0018_0000, 32'h0000_0080);
        unlock(32'h0018_0000);
        h.store(32'h0018_0000, 32'h0000_0030);
        check(n_start, 3);
        check(flag, 1);
        @(posedge clk);
        protect <= 4'h0;
        $display("bad sequence test done");
    endtask
    task automatic t_secure;
        @(posedge clk);
        protect <= 4'hF;
        writer_mode <= 1'b1;
        @(negedge clk);
        check({sec_on, read_en}, 2);
        @(posedge clk);
        protect <= 4'h0;
        writer_mode <= 1'b0;
        @(negedge clk);
        check({sec_on, read_en}, 1);
        $display("security test done");
    endtask
    initial begin
        rst = 1'b1;
        protect = 4'h0;
        writer_mode = 1'b0;
        arr_done = 1'b0;
        arr_fail = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check({flag, read_en, fetch_en}, 7);
        t_program;
        t_erase(32'h0000_0000, 32'h0000_0010, 1'b1);
        t_erase(32'h0018_0000, 32'h0000_0030, 1'b0);
        t_bad;
        t_secure;
        end_of_test;
    end
endmodule // testbench
bind fcs_sequencer fcs_properties chk (.CLK(CLK), .RST(RST), .WR_STB(WR_STB),
    .PROTECT(PROTECT), .WRITER_MODE(WRITER_MODE), .READY_BUSY_FLAG(READY_BUSY_FLAG),
    .READ_EN(READ_EN), .FETCH_EN(FETCH_EN), .SECURITY_ON(SECURITY_ON),
    .ARR_START(ARR_START), .ARR_OP(ARR_OP), .ARR_WSTB(ARR_WSTB));
